// ### core/ipfr_defines.svh
// constants for the input pin function router: offsets, field positions,
// reset values and counts; included by the package and the design modules
`ifndef IPFR_DEFINES_SVH
`define IPFR_DEFINES_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define IPFR_N_PINS       17
`define IPFR_N_FUNC       21
`define IPFR_CODE_W       8
`define IPFR_IDX_W        5
`define IPFR_ADDR_W       12

// ****************************************************************
// function codes
// ****************************************************************
`define IPFR_TRUE_MAX     8'h14
`define IPFR_INV_BASE     8'h64
`define IPFR_INV_MAX      8'h78
`define IPFR_N_PLAIN      14
`define IPFR_PEDAL_BASE   16

// ****************************************************************
// register map
// ****************************************************************
`define IPFR_PIN_BASE     12'h000
`define IPFR_CTRL_OFS     12'h050
`define IPFR_STAT_OFS     12'h054
`define IPFR_OUT_REV_BIT  0
`define IPFR_IN_REV_BIT   1
`define IPFR_OUT_REV_RST  1'h0
`define IPFR_IN_REV_RST   1'h0
`define IPFR_RESP_OKAY    2'h0
`define IPFR_RESP_SLVERR  2'h2

`endif

// ### core/ipfr_pkg.sv
// types shared by the router and its code memory
// assumes ipfr_defines.svh sits on the include path
`include "ipfr_defines.svh"

package ipfr_pkg;

  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} ipfr_rd_state_t;

  typedef struct packed {
    logic [`IPFR_N_PINS-1:0][`IPFR_CODE_W-1:0] codes;
    logic [`IPFR_CODE_W-1:0]                   rd_data;
  } ipfr_mem_state_t;

  typedef struct packed {
    logic [`IPFR_N_PINS-1:0] sync1;
    logic [`IPFR_N_PINS-1:0] sync2;
    logic [`IPFR_N_PINS-1:0] sync3;
    logic [`IPFR_N_PINS-1:0] filt;
    logic [`IPFR_N_FUNC-1:0] func_out;
    logic                    out_rev;
    logic                    in_rev;
    logic                    aw_full;
    logic                    w_full;
    logic [`IPFR_ADDR_W-1:0] aw_addr;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    ipfr_rd_state_t          rd_st;
    logic                    arready;
    logic [`IPFR_ADDR_W-1:0] ar_addr;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } ipfr_state_t;

endpackage : ipfr_pkg

// ### core/ipfr_code_mem.sv
// per-pin function code store, one word per input pin
// assumes one writer at a time; read data appear one edge after rd_idx
`timescale 1ns/1ns
`include "ipfr_defines.svh"

module ipfr_code_mem (
  input  wire logic                                      clk,
  input  wire logic                                      rst_b,
  input  wire logic                                      we,
  input  wire logic [`IPFR_IDX_W-1:0]                    wr_idx,
  input  wire logic [`IPFR_CODE_W-1:0]                   wr_data,
  input  wire logic [`IPFR_IDX_W-1:0]                    rd_idx,
  output logic      [`IPFR_CODE_W-1:0]                   rd_data,
  output logic      [`IPFR_N_PINS-1:0][`IPFR_CODE_W-1:0] codes
);

  // plain pins count up from zero, pedal pins jump to the pedal codes
  function automatic logic [`IPFR_N_PINS-1:0][`IPFR_CODE_W-1:0] dflt_codes();
    logic [`IPFR_N_PINS-1:0][`IPFR_CODE_W-1:0] c;
    c = '0;
    for (int i = 0; i < `IPFR_N_PINS; i++) begin
      if (i < `IPFR_N_PLAIN) begin
        c[i] = `IPFR_CODE_W'(i);
      end else begin
        c[i] = `IPFR_CODE_W'(`IPFR_PEDAL_BASE + i - `IPFR_N_PLAIN);
      end
    end
    return c;
  endfunction : dflt_codes

  localparam logic [`IPFR_N_PINS-1:0][`IPFR_CODE_W-1:0] DFLT = dflt_codes();

  ipfr_pkg::ipfr_mem_state_t q;
  ipfr_pkg::ipfr_mem_state_t d;

  always_comb begin
    d = q;
    if (we && (wr_idx < `IPFR_IDX_W'(`IPFR_N_PINS))) begin
      d.codes[wr_idx] = wr_data;
    end
    if (rd_idx < `IPFR_IDX_W'(`IPFR_N_PINS)) begin
      d.rd_data = q.codes[rd_idx];
    end else begin
      d.rd_data = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{codes: DFLT, rd_data: '0};
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rd_data;
  assign codes   = q.codes;

  default clocking mem_cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  dflt_codes_a: assert property ($rose(rst_b) |-> codes == DFLT)
    else $error("code store left reset without default codes");
  code_write_a: assert property (we && wr_idx < 5'h11 |=> codes[$past(wr_idx)] == $past(wr_data))
    else $error("pin code write not stored");

endmodule : ipfr_code_mem

// ### core/ipfr_router.sv
// input pin function router with its AXI4-Lite register slave
// assumes input pins are asynchronous to CLK; one AXI master on the bus
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "ipfr_defines.svh"

module ipfr_router (
  input  wire logic                    CLK,
  input  wire logic                    RST_B,
  input  wire logic                    IN_PIN_A0,
  input  wire logic                    IN_PIN_A1,
  input  wire logic                    IN_PIN_A2,
  input  wire logic                    IN_PIN_A3,
  input  wire logic                    IN_PIN_A4,
  input  wire logic                    IN_PIN_A5,
  input  wire logic                    IN_PIN_A6,
  input  wire logic                    IN_PIN_A7,
  input  wire logic                    IN_PIN_B0,
  input  wire logic                    IN_PIN_B1,
  input  wire logic                    IN_PIN_B2,
  input  wire logic                    IN_PIN_B3,
  input  wire logic                    IN_PIN_B4,
  input  wire logic                    IN_PIN_B5,
  input  wire logic                    IN_PIN_C0,
  input  wire logic                    IN_PIN_C1,
  input  wire logic                    IN_PIN_C2,
  output logic      [`IPFR_N_FUNC-1:0] FUNC_OUT,
  input  wire logic [`IPFR_ADDR_W-1:0] AWADDR,
  input  wire logic                    AWVALID,
  output logic                         AWREADY,
  input  wire logic [31:0]             WDATA,
  input  wire logic [3:0]              WSTRB,
  input  wire logic                    WVALID,
  output logic                         WREADY,
  output logic      [1:0]              BRESP,
  output logic                         BVALID,
  input  wire logic                    BREADY,
  input  wire logic [`IPFR_ADDR_W-1:0] ARADDR,
  input  wire logic                    ARVALID,
  output logic                         ARREADY,
  output logic      [31:0]             RDATA,
  output logic      [1:0]              RRESP,
  output logic                         RVALID,
  input  wire logic                    RREADY
);

  // ****************************************************************
  // decoding helpers
  // ****************************************************************
  // {valid, inverted, function index}
  function automatic logic [`IPFR_IDX_W+1:0] dec_code(input logic [`IPFR_CODE_W-1:0] c);
    logic [`IPFR_CODE_W-1:0] t;
    t = c - `IPFR_INV_BASE;
    if (c <= `IPFR_TRUE_MAX) begin
      return {1'b1, 1'b0, c[`IPFR_IDX_W-1:0]};
    end else if (c >= `IPFR_INV_BASE && c <= `IPFR_INV_MAX) begin
      return {1'b1, 1'b1, t[`IPFR_IDX_W-1:0]};
    end else begin
      return '0;
    end
  endfunction : dec_code

  // {hit, pin index}; low address bits ignored
  function automatic logic [`IPFR_IDX_W:0] dec_pin(input logic [`IPFR_ADDR_W-1:0] a);
    logic [`IPFR_ADDR_W-3:0] w;
    w = a[`IPFR_ADDR_W-1:2] - (`IPFR_ADDR_W-2)'(`IPFR_PIN_BASE >> 2);
    return {w < (`IPFR_ADDR_W-2)'(`IPFR_N_PINS), w[`IPFR_IDX_W-1:0]};
  endfunction : dec_pin

  // ****************************************************************
  // state
  // ****************************************************************
  ipfr_pkg::ipfr_state_t q;
  ipfr_pkg::ipfr_state_t d;

  logic [`IPFR_N_PINS-1:0]                   pins;
  logic [`IPFR_N_PINS-1:0][`IPFR_CODE_W-1:0] codes;
  logic [`IPFR_CODE_W-1:0]                   mem_rd;
  logic [`IPFR_IDX_W-1:0]                    mem_rd_idx;
  logic                                      mem_we;
  logic [`IPFR_N_FUNC-1:0]                   func_raw;
  logic                                      commit;
  logic [`IPFR_IDX_W:0]                      wr_pin;
  logic [`IPFR_IDX_W:0]                      rd_pin;
  logic [`IPFR_IDX_W:0]                      ar_pin;
  logic [`IPFR_IDX_W+1:0]                    dc;

  assign pins = {IN_PIN_C2, IN_PIN_C1, IN_PIN_C0, IN_PIN_B5, IN_PIN_B4, IN_PIN_B3,
                 IN_PIN_B2, IN_PIN_B1, IN_PIN_B0, IN_PIN_A7, IN_PIN_A6, IN_PIN_A5,
                 IN_PIN_A4, IN_PIN_A3, IN_PIN_A2, IN_PIN_A1, IN_PIN_A0};

  assign commit     = q.aw_full && q.w_full && !q.bvalid;
  assign wr_pin     = dec_pin(q.aw_addr);
  assign rd_pin     = dec_pin(q.ar_addr);
  assign mem_we     = commit && wr_pin[`IPFR_IDX_W] && q.w_strb[0];
  // read index taken straight from the bus so memory data are ready in RD_WAIT
  assign ar_pin     = dec_pin(ARADDR);
  assign mem_rd_idx = ar_pin[`IPFR_IDX_W-1:0];

  ipfr_code_mem u_code_mem (
    .clk     (CLK),
    .rst_b   (RST_B),
    .we      (mem_we),
    .wr_idx  (wr_pin[`IPFR_IDX_W-1:0]),
    .wr_data (q.w_data[`IPFR_CODE_W-1:0]),
    .rd_idx  (mem_rd_idx),
    .rd_data (mem_rd),
    .codes   (codes)
  );

  // ****************************************************************
  // pin mapping
  // ****************************************************************
  always_comb begin
    func_raw = '0;
    dc       = '0;
    for (int i = 0; i < `IPFR_N_PINS; i++) begin
      dc = dec_code(codes[i]);
      if (dc[`IPFR_IDX_W+1]) begin
        // both inversions stack, so global plus per-pin cancel
        func_raw[dc[`IPFR_IDX_W-1:0]] = func_raw[dc[`IPFR_IDX_W-1:0]] |
          (q.filt[i] ^ q.in_rev ^ dc[`IPFR_IDX_W]);
      end
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d = q;
    // three stages; a level counts once stages two and three agree
    d.sync1 = pins;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    for (int i = 0; i < `IPFR_N_PINS; i++) begin
      if (q.sync2[i] == q.sync3[i]) begin
        d.filt[i] = q.sync3[i];
      end
    end
    d.func_out = func_raw ^ {`IPFR_N_FUNC{q.out_rev}};

    // write channel: address and data accepted in either order
    if (AWVALID && q.awready) begin
      d.aw_full = 1'b1;
      d.aw_addr = AWADDR;
    end
    if (WVALID && q.wready) begin
      d.w_full = 1'b1;
      d.w_data = WDATA;
      d.w_strb = WSTRB;
    end
    if (commit) begin
      d.aw_full = 1'b0;
      d.w_full  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = `IPFR_RESP_OKAY;
      if (q.aw_addr[`IPFR_ADDR_W-1:2] == `IPFR_CTRL_OFS >> 2) begin
        if (q.w_strb[0]) begin
          d.out_rev = q.w_data[`IPFR_OUT_REV_BIT];
          d.in_rev  = q.w_data[`IPFR_IN_REV_BIT];
        end
      end else if (!wr_pin[`IPFR_IDX_W]) begin
        // status word is read only, so it answers like a hole
        d.bresp = `IPFR_RESP_SLVERR;
      end
    end
    if (q.bvalid && BREADY) begin
      d.bvalid = 1'b0;
    end
    d.awready = !d.aw_full && !d.bvalid;
    d.wready  = !d.w_full && !d.bvalid;

    // read channel
    case (q.rd_st)
      ipfr_pkg::RD_IDLE: begin
        if (ARVALID && q.arready) begin
          d.ar_addr = ARADDR;
          d.rd_st   = ipfr_pkg::RD_WAIT;
        end
      end
      ipfr_pkg::RD_WAIT: begin
        d.rvalid = 1'b1;
        d.rresp  = `IPFR_RESP_OKAY;
        d.rd_st  = ipfr_pkg::RD_RESP;
        if (rd_pin[`IPFR_IDX_W]) begin
          d.rdata = {24'h000000, mem_rd};
        end else if (q.ar_addr[`IPFR_ADDR_W-1:2] == `IPFR_CTRL_OFS >> 2) begin
          d.rdata = {30'h00000000, q.in_rev, q.out_rev};
        end else if (q.ar_addr[`IPFR_ADDR_W-1:2] == `IPFR_STAT_OFS >> 2) begin
          d.rdata = {11'h000, q.func_out};
        end else begin
          d.rdata = 32'h00000000;
          d.rresp = `IPFR_RESP_SLVERR;
        end
      end
      ipfr_pkg::RD_RESP: begin
        if (RREADY) begin
          d.rvalid = 1'b0;
          d.rd_st  = ipfr_pkg::RD_IDLE;
        end
      end
      default: begin
        d.rd_st  = ipfr_pkg::RD_IDLE;
        d.rvalid = 1'b0;
      end
    endcase
    d.arready = (d.rd_st == ipfr_pkg::RD_IDLE);
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      q         <= '0;
      q.out_rev <= `IPFR_OUT_REV_RST;
      q.in_rev  <= `IPFR_IN_REV_RST;
      q.rd_st   <= ipfr_pkg::RD_IDLE;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign FUNC_OUT = q.func_out;
  assign AWREADY  = q.awready;
  assign WREADY   = q.wready;
  assign BVALID   = q.bvalid;
  assign BRESP    = q.bresp;
  assign ARREADY  = q.arready;
  assign RVALID   = q.rvalid;
  assign RDATA    = q.rdata;
  assign RRESP    = q.rresp;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking rt_cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // pin 0 holds a code outside both sets
  logic bad0;
  always_comb begin
    bad0 = 1'b1;
    if (codes[0] <= 8'h14 || (codes[0] >= 8'h64 && codes[0] <= 8'h78)) begin
      bad0 = 1'b0;
    end
  end

  sequence rd_taken_s;
    ARVALID && ARREADY;
  endsequence
  sequence rd_answer_s;
    ##2 RVALID;
  endsequence

  pin_settle_a: assert property (q.sync2 == q.sync3 |=> q.filt == $past(q.sync3))
    else $error("agreed pin level not taken");
  out_reverse_a: assert property (1'b1 |=> FUNC_OUT == ($past(func_raw) ^ {21{$past(q.out_rev)}}))
    else $error("function outputs not reversed as set");
  true_route_a: assert property (codes[1] == 8'h14 && (q.filt[1] ^ q.in_rev) |-> func_raw[20])
    else $error("true code did not drive its function");
  inv_route_a: assert property (codes[1] == 8'h64 && !q.in_rev && !q.filt[1] |-> func_raw[0])
    else $error("inverted code did not drive its function");
  or_merge_a: assert property (codes[0] == 8'h14 && codes[1] == 8'h14 && !q.in_rev &&
    (q.filt[0] || q.filt[1]) |-> func_raw[20])
    else $error("shared function missed a pin");
  active_high_a: assert property (codes[2] == 8'h02 && !q.in_rev |-> func_raw[2] >= q.filt[2])
    else $error("high pin not active");
  bad_code_a: assert property (bad0 && $changed(q.filt[0]) && $stable(q.filt[16:1]) &&
    $stable(codes) && $stable(q.in_rev) |-> $stable(func_raw))
    else $error("unmapped code drove a function");
  in_reverse_a: assert property (codes[2] == 8'h02 && q.in_rev && !q.filt[2] |-> func_raw[2])
    else $error("input reverse not applied");
  double_inv_a: assert property (codes[0] == 8'h68 && q.in_rev && q.filt[0] |-> func_raw[4])
    else $error("stacked inversions did not cancel");
  read_latency_a: assert property (rd_taken_s |-> rd_answer_s)
    else $error("read answer not two edges after address");
  write_resp_a: assert property (commit |=> BVALID)
    else $error("write response late");
  resp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before taken");

endmodule : ipfr_router

// ### verif/ipfr_switch_model.sv
// partner model: operator switches, pedal contacts and edge sensors
// assumes the bench commands the contact levels, one contact per router pin
`timescale 1ns/1ns
`include "ipfr_defines.svh"

module ipfr_switch_model (
  input  wire logic [`IPFR_N_PINS-1:0] level_cmd,
  input  wire logic                    clk,
  output logic      [`IPFR_N_PINS-1:0] pin_lvl
);
  // ****************************************************************
  // contact levels
  // ****************************************************************
  logic [`IPFR_N_PINS-1:0] lvl_q = 17'h00000;

  // contacts move just after an edge; a closed contact reads high
  always @(posedge clk) begin
    lvl_q <= level_cmd;
  end

  assign pin_lvl = lvl_q;
endmodule : ipfr_switch_model

// ### verif/test_input_pin_function_router.sv
// self-checking bench for the input pin function router
// assumes the switch model drives the pins and the bench is the only bus master
`timescale 1ns/1ns
`include "ipfr_defines.svh"

module test_input_pin_function_router;
  logic        CLK, RST_B;
  logic [16:0] pin_cmd, pin_lvl, pins_m;
  logic [20:0] FUNC_OUT;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd;
  logic [1:0]  BRESP, RRESP, resp;
  logic [3:0]  strb;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  logic        in_rev_m, out_rev_m;
  logic [7:0]  codes_m [17];
  logic [7:0]  bad_codes [4] = '{8'h15, 8'h63, 8'h79, 8'hFF};
  int          err_count, n_tests;

  ipfr_switch_model sw (.clk(CLK), .level_cmd(pin_cmd), .pin_lvl(pin_lvl));

  ipfr_router uut (
    .CLK(CLK), .RST_B(RST_B), .FUNC_OUT(FUNC_OUT),
    .IN_PIN_A0(pin_lvl[0]), .IN_PIN_A1(pin_lvl[1]), .IN_PIN_A2(pin_lvl[2]), .IN_PIN_A3(pin_lvl[3]),
    .IN_PIN_A4(pin_lvl[4]), .IN_PIN_A5(pin_lvl[5]), .IN_PIN_A6(pin_lvl[6]), .IN_PIN_A7(pin_lvl[7]),
    .IN_PIN_B0(pin_lvl[8]), .IN_PIN_B1(pin_lvl[9]), .IN_PIN_B2(pin_lvl[10]), .IN_PIN_B3(pin_lvl[11]),
    .IN_PIN_B4(pin_lvl[12]), .IN_PIN_B5(pin_lvl[13]), .IN_PIN_C0(pin_lvl[14]), .IN_PIN_C1(pin_lvl[15]),
    .IN_PIN_C2(pin_lvl[16]), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(strb), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY)
  );

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  // ****************************************************************
  // reference and checks
  // ****************************************************************
  function automatic logic [20:0] model_out();
    logic [20:0] f;
    logic        lv;
    f = 21'h000000;
    for (int i = 0; i < 17; i++) begin
      lv = pins_m[i] ^ in_rev_m;
      if (codes_m[i] <= 8'h14) f[codes_m[i]] = f[codes_m[i]] | lv;
      else if (codes_m[i] >= 8'h64 && codes_m[i] <= 8'h78) f[codes_m[i] - 8'h64] = f[codes_m[i] - 8'h64] | ~lv;
    end
    return out_rev_m ? ~f : f;
  endfunction : model_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic final_report();
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  // ****************************************************************
  // bus tasks
  // ****************************************************************
  // write address and data leave independently; done on the response
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge CLK);
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    forever begin
      @(posedge CLK);
      if (aw_p && AWREADY === 1'b1) begin
        aw_p = 1'b0;
        AWVALID <= 1'b0;
      end
      if (w_p && WREADY === 1'b1) begin
        w_p = 1'b0;
        WVALID <= 1'b0;
      end
      if (BVALID === 1'b1) begin
        r = BRESP;
        BREADY <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge CLK);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    forever begin
      @(posedge CLK);
      if (ARVALID && ARREADY === 1'b1) ARVALID <= 1'b0;
      if (RVALID === 1'b1) begin
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  task automatic set_code(input int i, input logic [7:0] c);
    axi_wr(12'(4 * i), {24'h000000, c}, resp);
    codes_m[i] = c;
    chk(resp, `IPFR_RESP_OKAY, "code write response");
  endtask : set_code

  task automatic set_ctrl(input logic [1:0] v);
    axi_wr(`IPFR_CTRL_OFS, {30'h00000000, v}, resp);
    out_rev_m = v[0];
    in_rev_m = v[1];
  endtask : set_ctrl

  // three sync stages, filter and output flop fit inside this wait
  task automatic apply(input logic [16:0] p);
    pins_m = p;
    pin_cmd <= p;
    repeat (8) @(posedge CLK);
    chk(32'(FUNC_OUT), 32'(model_out()), "function outputs");
  endtask : apply

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    {RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h00;
    {AWADDR, ARADDR, WDATA, pin_cmd, pins_m} = 90'h0;
    {in_rev_m, out_rev_m, err_count, n_tests} = '0;
    strb = 4'hF;
    for (int i = 0; i < 17; i++) codes_m[i] = (i < 14) ? 8'(i) : 8'(i + 2);
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      axi_rd(12'(4 * i), rd, resp);
      chk(rd, 32'(codes_m[i]), "code reset value");
      chk(resp, `IPFR_RESP_OKAY, "code read response");
    end
    axi_rd(`IPFR_CTRL_OFS, rd, resp);
    chk(rd, 32'h00000000, "control reset value");
    apply(17'h00000);
    for (int i = 0; i < 17; i++) apply(17'h00001 << i);
    for (int k = 0; k < 21; k++) begin
      set_code(0, 8'(k));
      set_code(1, 8'(k + 100));
      apply(17'h00003);
      apply(17'h00000);
    end
    set_code(1, 8'h14);
    for (int m = 0; m < 4; m++) apply(17'(m));
    for (int b = 0; b < 4; b++) begin
      set_code(0, bad_codes[b]);
      apply(17'h00001);
      apply(17'h00000);
    end
    set_code(0, 8'h68);
    for (int v = 0; v < 4; v++) begin
      set_ctrl(2'(v));
      chk(resp, `IPFR_RESP_OKAY, "control write response");
      apply(17'h00000);
      apply(17'h00001);
      axi_rd(`IPFR_STAT_OFS, rd, resp);
      chk(rd, 32'(model_out()), "status value");
    end
    axi_wr(12'h060, 32'h00000001, resp);
    chk(resp, `IPFR_RESP_SLVERR, "unmapped write response");
    axi_wr(`IPFR_STAT_OFS, 32'h00000001, resp);
    chk(resp, `IPFR_RESP_SLVERR, "status write response");
    strb <= 4'h0;
    axi_wr(12'h008, 32'h00000077, resp);
    chk(resp, `IPFR_RESP_OKAY, "masked write response");
    strb <= 4'hF;
    axi_rd(12'h008, rd, resp);
    chk(rd, 32'(codes_m[2]), "masked write ignored");
    axi_rd(12'h060, rd, resp);
    chk(rd, 32'h00000000, "unmapped read data");
    chk(resp, `IPFR_RESP_SLVERR, "unmapped read response");
    final_report();
  end

  // whole run is about a thousand cycles
  initial begin
    repeat (20000) @(posedge CLK);
    err_count++;
    final_report();
  end
endmodule : test_input_pin_function_router
